//--- rtl/spc_cfg.svh
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPC_ADDR_PORT_EN 16'h3c48
`define SPC_ADDR_GLOBAL_EN 16'h4141
`define SPC_ADDR_P4_SEL 16'h416e
`define SPC_ADDR_P5_SEL 16'h416f
`define SPC_ADDR_TIMEOUT 16'h4171
`define SPC_ADDR_TOGGLE 16'h4176

// ----------------------------------------
// Reset values and field layout
// ----------------------------------------
`define SPC_RST_PORT_EN 8'h00
`define SPC_RST_GLOBAL_EN 8'h00
`define SPC_RST_PIN_SEL 8'h00
`define SPC_RST_TIMEOUT 8'h05
`define SPC_RST_TOGGLE 8'h05
`define SPC_BIT_P4_EN 5
`define SPC_BIT_P5_EN 6
`define SPC_BIT_GLOBAL_EN 0
`define SPC_MASK_PORT_EN 8'h60
`define SPC_MASK_GLOBAL_EN 8'h01
`define SPC_MASK_TIMEOUT 8'h07

// ----------------------------------------
// Pin select codes
// ----------------------------------------
`define SPC_SEL_P4_GPIO_SIXTY_SIX 8'h42
`define SPC_SEL_P4_GPIO_FIVE 8'h05
`define SPC_SEL_P5_GPIO_SIX 8'h06
`define SPC_SEL_P5_GPIO_FOUR 8'h04

// ----------------------------------------
// Link state window and timing
// ----------------------------------------
`define SPC_LTSSM_FIRST_STUCK 4'h4
`define SPC_LTSSM_LAST_STUCK 4'h9
`define SPC_TMO_CODE_100MS 3'h1
`define SPC_TMO_CODE_250MS 3'h2
`define SPC_TMO_CODE_500MS 3'h3
`define SPC_TMO_CODE_750MS 3'h4
`define SPC_TMO_CODE_1S 3'h5
`define SPC_TMO_CODE_2S 3'h6
`define SPC_TMO_NONE_MS 16'h0000
`define SPC_TMO_100MS 16'h0064
`define SPC_TMO_250MS 16'h00fa
`define SPC_TMO_500MS 16'h01f4
`define SPC_TMO_750MS 16'h02ee
`define SPC_TMO_1S_MS 16'h03e8
`define SPC_TMO_2S_MS 16'h07d0
`define SPC_OFF_BASE_MS 16'h015e
`define SPC_OFF_STEP_MS 16'h000a
`define SPC_MS_IN_NS 32'h000f4240
`define SPC_CLK_PERIOD_NS 32'h00000014

`endif

//--- rtl/spc_pkg.sv
`include "spc_cfg.svh"

package spc_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {WD_IDLE, WD_WATCH, WD_TOGGLE} spc_wd_state_t;

	typedef struct packed {
		spc_wd_state_t state;
		logic [15:0] cnt;
		logic [3:0] last;
		logic low;
	} spc_wd_t;

	typedef struct packed {
		logic [7:0] port_en;
		logic [7:0] global_en;
		logic [7:0] p4_sel;
		logic [7:0] p5_sel;
		logic [7:0] timeout;
		logic [7:0] toggle;
		logic [7:0] rdata;
		logic p4_ctl;
		logic p5_ctl;
		logic g66;
		logic g66_oe_n;
		logic g6;
		logic g6_oe_n;
		logic g5;
		logic g5_oe_n;
		logic g4;
		logic g4_oe_n;
	} spc_top_t;

	// ----------------------------------------
	// Decoding shared by both ports
	// ----------------------------------------
	function automatic logic [15:0] timeout_ms(input logic [2:0] code);
		case (code)
			`SPC_TMO_CODE_100MS: timeout_ms = `SPC_TMO_100MS;
			`SPC_TMO_CODE_250MS: timeout_ms = `SPC_TMO_250MS;
			`SPC_TMO_CODE_500MS: timeout_ms = `SPC_TMO_500MS;
			`SPC_TMO_CODE_750MS: timeout_ms = `SPC_TMO_750MS;
			`SPC_TMO_CODE_1S: timeout_ms = `SPC_TMO_1S_MS;
			`SPC_TMO_CODE_2S: timeout_ms = `SPC_TMO_2S_MS;
			// Reserved code treated as no timeout, the safe reading
			default: timeout_ms = `SPC_TMO_NONE_MS;
		endcase
	endfunction

	function automatic logic [15:0] off_ms(input logic [7:0] val);
		off_ms = `SPC_OFF_BASE_MS + ({8'h00, val} * `SPC_OFF_STEP_MS);
	endfunction

	function automatic logic is_stuck(input logic [3:0] st);
		is_stuck = (st >= `SPC_LTSSM_FIRST_STUCK) && (st <= `SPC_LTSSM_LAST_STUCK);
	endfunction

endpackage

//--- rtl/spc_ms_tick.sv
`timescale 1ns/1ns
`default_nettype none

`include "spc_cfg.svh"

module spc_ms_tick #(
	parameter int TICK_CYCLES = `SPC_MS_IN_NS / `SPC_CLK_PERIOD_NS
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	output logic o_tick
);

	localparam int CW = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} spc_tick_t;

	spc_tick_t s;
	spc_tick_t next_s;

	// ----------------------------------------
	// Millisecond divider
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == CW'(TICK_CYCLES - 1)) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + CW'(1);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_tick = s.tick;

endmodule

`default_nettype wire

//--- rtl/spc_link_watchdog.sv
`timescale 1ns/1ns
`default_nettype none

`include "spc_cfg.svh"

module spc_link_watchdog (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_ms_tick,
	input wire logic i_enable,
	input wire logic [3:0] i_link_state_status,
	input wire logic [15:0] i_timeout_ms,
	input wire logic [15:0] i_off_ms,
	output logic o_power_low
);

	spc_pkg::spc_wd_t s;
	spc_pkg::spc_wd_t next_s;

	// ----------------------------------------
	// Stuck link observer and off pulse
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.last = i_link_state_status;
		case (s.state)
			spc_pkg::WD_IDLE: begin
				next_s.cnt = '0;
				next_s.low = 1'b0;
				if (i_enable) begin
					next_s.state = spc_pkg::WD_WATCH;
				end
			end
			spc_pkg::WD_WATCH: begin
				if (!i_enable) begin
					next_s.state = spc_pkg::WD_IDLE;
				end else if (i_link_state_status != s.last
						|| !spc_pkg::is_stuck(i_link_state_status)) begin
					next_s.cnt = '0;
				end else if (i_timeout_ms == `SPC_TMO_NONE_MS) begin
					next_s.cnt = '0;
				end else if (i_ms_tick) begin
					if (s.cnt + 16'h0001 >= i_timeout_ms) begin
						next_s.state = spc_pkg::WD_TOGGLE;
						next_s.cnt = '0;
						next_s.low = 1'b1;
					end else begin
						next_s.cnt = s.cnt + 16'h0001;
					end
				end
			end
			spc_pkg::WD_TOGGLE: begin
				// Dropping enable ends the pulse at once; power follows config
				if (!i_enable) begin
					next_s.state = spc_pkg::WD_IDLE;
					next_s.cnt = '0;
					next_s.low = 1'b0;
				end else if (i_ms_tick) begin
					if (s.cnt + 16'h0001 >= i_off_ms) begin
						next_s.state = spc_pkg::WD_WATCH;
						next_s.cnt = '0;
						next_s.low = 1'b0;
					end else begin
						next_s.cnt = s.cnt + 16'h0001;
					end
				end
			end
			default: begin
				next_s.state = spc_pkg::WD_IDLE;
				next_s.cnt = '0;
				next_s.low = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s <= '{state: spc_pkg::WD_IDLE, cnt: 16'h0000, last: 4'h0, low: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign o_power_low = s.low;

endmodule

`default_nettype wire

//--- rtl/spc_split_power_ctrl.sv
// Operation
// - Split offered only on downstream ports four, five
// - Config accepted in configuration stage, bus or OTP
// - Port power pin still drives 2.0 half
// - Extra GPIO output drives SuperSpeed half only
// - No overcurrent sensing on split output
// - Port four: pin 66 or 5; five: 6 or 4
// - Port four select: 0x42 pin 66, 0x05 pin 5
// - Port five select: 0x06 pin 6, 0x04 pin 4
// - Port enable bits five and six, reset zero
// - Global enable bit zero, others read zero
// - Invalid link for timeout pulses split output
// - Timer clears and restarts after every timeout
// - Stuck means staying in states four to nine
// - Timeout register resets to one second code
// - Timeout zero disables pulsing entirely
// - Output held low for configured toggle time
// - Three-bit timeout code table, upper bits zero
// - Off time 350 ms plus 10 ms per count
`timescale 1ns/1ns
`default_nettype none

`include "spc_cfg.svh"

module spc_split_power_ctrl #(
	parameter int MS_TICK_CYCLES = `SPC_MS_IN_NS / `SPC_CLK_PERIOD_NS
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_cfg_stage,
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [15:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	output logic [7:0] o_cfg_rdata,
	input wire logic i_port4_power_request,
	input wire logic i_port5_power_request,
	input wire logic [3:0] i_port4_link_state_status,
	input wire logic [3:0] i_port5_link_state_status,
	output logic o_port4_power_control_pin,
	output logic o_port5_power_control_pin,
	output logic o_gpio_sixty_six,
	output logic o_gpio_sixty_six_oe_n,
	output logic o_gpio_six,
	output logic o_gpio_six_oe_n,
	output logic o_gpio_five,
	output logic o_gpio_five_oe_n,
	output logic o_gpio_four,
	output logic o_gpio_four_oe_n
);

	spc_pkg::spc_top_t s;
	spc_pkg::spc_top_t next_s;

	logic ms_tick;
	logic p4_split;
	logic p5_split;
	logic p4_low;
	logic p5_low;
	logic [15:0] tmo_ms;
	logic [15:0] off_ms;
	logic port4_superspeed_power_out;
	logic port5_superspeed_power_out;
	logic cfg_write;

	// ----------------------------------------
	// Timebase
	// ----------------------------------------
	spc_ms_tick #(
		.TICK_CYCLES(MS_TICK_CYCLES)
	) u_tick (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.o_tick(ms_tick)
	);

	// ----------------------------------------
	// Split enables and timing decode
	// ----------------------------------------
	// A port splits only when both its own bit and the global bit are set
	assign p4_split = s.global_en[`SPC_BIT_GLOBAL_EN] && s.port_en[`SPC_BIT_P4_EN];
	assign p5_split = s.global_en[`SPC_BIT_GLOBAL_EN] && s.port_en[`SPC_BIT_P5_EN];
	assign tmo_ms = spc_pkg::timeout_ms(s.timeout[2:0]);
	assign off_ms = spc_pkg::off_ms(s.toggle);

	// ----------------------------------------
	// Per-port link watchdogs
	// ----------------------------------------
	spc_link_watchdog u_wd_p4 (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_ms_tick(ms_tick),
		.i_enable(p4_split),
		.i_link_state_status(i_port4_link_state_status),
		.i_timeout_ms(tmo_ms),
		.i_off_ms(off_ms),
		.o_power_low(p4_low)
	);

	spc_link_watchdog u_wd_p5 (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_ms_tick(ms_tick),
		.i_enable(p5_split),
		.i_link_state_status(i_port5_link_state_status),
		.i_timeout_ms(tmo_ms),
		.i_off_ms(off_ms),
		.o_power_low(p5_low)
	);

	// ----------------------------------------
	// SuperSpeed half power
	// ----------------------------------------
	// Follows the port power request, forced low for a reset pulse
	assign port4_superspeed_power_out = i_port4_power_request && !p4_low;
	assign port5_superspeed_power_out = i_port5_power_request && !p5_low;

	// Writes outside the configuration stage are dropped
	assign cfg_write = i_cfg_wr && i_cfg_stage;

	// ----------------------------------------
	// Registers, read port and pin drive
	// ----------------------------------------
	always_comb begin
		next_s = s;

		if (cfg_write) begin
			case (i_cfg_addr)
				`SPC_ADDR_PORT_EN: begin
					next_s.port_en = i_cfg_wdata & `SPC_MASK_PORT_EN;
				end
				`SPC_ADDR_GLOBAL_EN: begin
					next_s.global_en = i_cfg_wdata & `SPC_MASK_GLOBAL_EN;
				end
				`SPC_ADDR_P4_SEL: begin
					next_s.p4_sel = i_cfg_wdata;
				end
				`SPC_ADDR_P5_SEL: begin
					next_s.p5_sel = i_cfg_wdata;
				end
				`SPC_ADDR_TIMEOUT: begin
					next_s.timeout = i_cfg_wdata & `SPC_MASK_TIMEOUT;
				end
				`SPC_ADDR_TOGGLE: begin
					next_s.toggle = i_cfg_wdata;
				end
				default: begin
					next_s.port_en = s.port_en;
				end
			endcase
		end

		if (i_cfg_rd) begin
			case (i_cfg_addr)
				`SPC_ADDR_PORT_EN: next_s.rdata = s.port_en;
				`SPC_ADDR_GLOBAL_EN: next_s.rdata = s.global_en;
				`SPC_ADDR_P4_SEL: next_s.rdata = s.p4_sel;
				`SPC_ADDR_P5_SEL: next_s.rdata = s.p5_sel;
				`SPC_ADDR_TIMEOUT: next_s.rdata = s.timeout;
				`SPC_ADDR_TOGGLE: next_s.rdata = s.toggle;
				default: next_s.rdata = 8'h00;
			endcase
		end

		// 2.0 half keeps its own pin whether or not the port splits
		next_s.p4_ctl = i_port4_power_request;
		next_s.p5_ctl = i_port5_power_request;

		// Split pins are pure outputs; there is no sense path back in
		next_s.g66 = 1'b0;
		next_s.g66_oe_n = 1'b1;
		next_s.g5 = 1'b0;
		next_s.g5_oe_n = 1'b1;
		next_s.g6 = 1'b0;
		next_s.g6_oe_n = 1'b1;
		next_s.g4 = 1'b0;
		next_s.g4_oe_n = 1'b1;

		if (p4_split && s.p4_sel == `SPC_SEL_P4_GPIO_SIXTY_SIX) begin
			next_s.g66 = port4_superspeed_power_out;
			next_s.g66_oe_n = 1'b0;
		end else if (p4_split && s.p4_sel == `SPC_SEL_P4_GPIO_FIVE) begin
			next_s.g5 = port4_superspeed_power_out;
			next_s.g5_oe_n = 1'b0;
		end

		if (p5_split && s.p5_sel == `SPC_SEL_P5_GPIO_SIX) begin
			next_s.g6 = port5_superspeed_power_out;
			next_s.g6_oe_n = 1'b0;
		end else if (p5_split && s.p5_sel == `SPC_SEL_P5_GPIO_FOUR) begin
			next_s.g4 = port5_superspeed_power_out;
			next_s.g4_oe_n = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s <= '{
				port_en: `SPC_RST_PORT_EN,
				global_en: `SPC_RST_GLOBAL_EN,
				p4_sel: `SPC_RST_PIN_SEL,
				p5_sel: `SPC_RST_PIN_SEL,
				timeout: `SPC_RST_TIMEOUT,
				toggle: `SPC_RST_TOGGLE,
				rdata: 8'h00,
				p4_ctl: 1'b0,
				p5_ctl: 1'b0,
				g66: 1'b0,
				g66_oe_n: 1'b1,
				g6: 1'b0,
				g6_oe_n: 1'b1,
				g5: 1'b0,
				g5_oe_n: 1'b1,
				g4: 1'b0,
				g4_oe_n: 1'b1
			};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_cfg_rdata = s.rdata;
	assign o_port4_power_control_pin = s.p4_ctl;
	assign o_port5_power_control_pin = s.p5_ctl;
	assign o_gpio_sixty_six = s.g66;
	assign o_gpio_sixty_six_oe_n = s.g66_oe_n;
	assign o_gpio_six = s.g6;
	assign o_gpio_six_oe_n = s.g6_oe_n;
	assign o_gpio_five = s.g5;
	assign o_gpio_five_oe_n = s.g5_oe_n;
	assign o_gpio_four = s.g4;
	assign o_gpio_four_oe_n = s.g4_oe_n;

endmodule

`default_nettype wire

//--- bench/spc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module spc_checker #(
	parameter int MS_TICK_CYCLES = 50000
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_cfg_rd,
	input wire logic [15:0] i_cfg_addr,
	input wire logic [7:0] o_cfg_rdata,
	input wire logic i_port4_power_request,
	input wire logic i_port5_power_request,
	input wire logic [3:0] i_port4_link_state_status,
	input wire logic o_port4_power_control_pin,
	input wire logic o_port5_power_control_pin,
	input wire logic o_gpio_sixty_six,
	input wire logic o_gpio_sixty_six_oe_n,
	input wire logic o_gpio_six_oe_n,
	input wire logic o_gpio_five,
	input wire logic o_gpio_five_oe_n,
	input wire logic o_gpio_four_oe_n
);
	// ----------------
	// Helpers
	// ----------------
	// One ms tick of slack, the timebase phase is unknown
	localparam int MIN_OFF = 349 * MS_TICK_CYCLES;
	localparam int MIN_STUCK = 99 * MS_TICK_CYCLES - 4;
	logic [3:0] last;
	logic held;
	int run;
	int low;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	assign held = i_port4_link_state_status == last && i_port4_link_state_status inside {[4:9]};
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			last <= 4'h0;
			run <= 0;
			low <= 0;
		end else begin
			last <= i_port4_link_state_status;
			run <= held ? run + 1 : 0;
			low <= (i_port4_power_request && !o_gpio_sixty_six && !o_gpio_sixty_six_oe_n) ? low + 1 : 0;
		end
	end
	// ----------------
	// Properties
	// ----------------
	sequence rd_of(logic [15:0] a);
		i_cfg_rd && i_cfg_addr == a;
	endsequence
	sequence steady_on;
		i_port4_power_request && $past(i_port4_power_request) && !o_gpio_sixty_six_oe_n;
	endsequence
	ctl_lag_a: assert property (
		!$past(i_sys_rst) |-> {o_port4_power_control_pin, o_port5_power_control_pin} ==
		$past({i_port4_power_request, i_port5_power_request})) else $error("power pin lag");
	one_pin_a: assert property (
		(o_gpio_sixty_six_oe_n || o_gpio_five_oe_n) && (o_gpio_six_oe_n || o_gpio_four_oe_n))
		else $error("two pins for a port");
	req_drop_a: assert property (
		$fell(i_port4_power_request) |=> !o_gpio_sixty_six && !o_gpio_five)
		else $error("split pin ignores request");
	glob_read_a: assert property (
		rd_of(16'h4141) |=> o_cfg_rdata[7:1] == 7'h00) else $error("global reserved set");
	port_read_a: assert property (
		rd_of(16'h3c48) |=> (o_cfg_rdata & 8'h9f) == 8'h00) else $error("port reserved set");
	tmo_read_a: assert property (
		rd_of(16'h4171) |=> o_cfg_rdata[7:3] == 5'h00) else $error("timeout upper set");
	off_min_a: assert property (
		$rose(o_gpio_sixty_six) |-> low <= 3 || low >= MIN_OFF) else $error("off time short");
	stuck_min_a: assert property (
		steady_on ##0 $fell(o_gpio_sixty_six) |-> run >= MIN_STUCK) else $error("early pulse");
endmodule
bind spc_split_power_ctrl spc_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_chk (
	.i_ref_clk(i_ref_clk),
	.i_sys_rst(i_sys_rst),
	.i_cfg_rd(i_cfg_rd),
	.i_cfg_addr(i_cfg_addr),
	.o_cfg_rdata(o_cfg_rdata),
	.i_port4_power_request(i_port4_power_request),
	.i_port5_power_request(i_port5_power_request),
	.i_port4_link_state_status(i_port4_link_state_status),
	.o_port4_power_control_pin(o_port4_power_control_pin),
	.o_port5_power_control_pin(o_port5_power_control_pin),
	.o_gpio_sixty_six(o_gpio_sixty_six),
	.o_gpio_sixty_six_oe_n(o_gpio_sixty_six_oe_n),
	.o_gpio_six_oe_n(o_gpio_six_oe_n),
	.o_gpio_five(o_gpio_five),
	.o_gpio_five_oe_n(o_gpio_five_oe_n),
	.o_gpio_four_oe_n(o_gpio_four_oe_n)
);
`default_nettype wire

//--- bench/spc_embedded_dev.sv
`timescale 1ns/1ns
`default_nettype none
module spc_embedded_dev (
	input wire logic i_ref_clk,
	input wire logic [1:0] i_pwr,
	input wire logic [1:0] i_pwr_oe_n,
	input wire logic [3:0] i_code,
	output logic [3:0] o_link_state_status
);
	// ----------------
	// Link state
	// ----------------
	// Unpowered it only sees receiver detect, itself a stuck state
	always_ff @(posedge i_ref_clk) begin
		o_link_state_status <= |(i_pwr & ~i_pwr_oe_n) ? i_code : 4'h5;
	end
endmodule
`default_nettype wire

//--- bench/spc_split_power_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module spc_split_power_ctrl_bench;
	localparam int MS = 5;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic stg = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] adr = 16'h0000;
	logic [7:0] wd = 8'h00;
	logic rq4 = 1'b0;
	logic rq5 = 1'b0;
	logic [3:0] c4 = 4'h0;
	logic [3:0] c5 = 4'h0;
	logic [7:0] rdat;
	logic [3:0] ls4;
	logic [3:0] ls5;
	logic p4;
	logic p5;
	wire [3:0] g;
	wire [3:0] gn;
	int failures = 0;
	int n_tests = 0;
	int n;
	int t;
	int o;
	int lo;
	logic [36:0] rt;
	logic [8:0] nt;
	logic [23:0] rv [7] = '{24'h3c4800, 24'h414100, 24'h416e00, 24'h416f00, 24'h417105,
		24'h417605, 24'h123400};
	logic [23:0] mk [3] = '{24'h3c4860, 24'h414101, 24'h417107};
	logic [36:0] rtab [6] = '{{16'h416e, 8'h42, 8'h20, 1'b1, 4'h7},
		{16'h416e, 8'h05, 8'h20, 1'b1, 4'hd}, {16'h416f, 8'h06, 8'h40, 1'b1, 4'hb},
		{16'h416f, 8'h04, 8'h40, 1'b1, 4'he}, {16'h416e, 8'h42, 8'h20, 1'b0, 4'hf},
		{16'h416e, 8'h42, 8'h00, 1'b1, 4'hf}};
	logic [8:0] ntab [6] = '{{4'h1, 4'h0, 1'b0}, {4'h1, 4'h3, 1'b0}, {4'h1, 4'ha, 1'b0},
		{4'h1, 4'h5, 1'b1}, {4'h0, 4'h7, 1'b0}, {4'h7, 4'h7, 1'b0}};
	int tms [6] = '{100, 250, 500, 750, 1000, 2000};
	always #10 clk = ~clk;
	spc_split_power_ctrl #(.MS_TICK_CYCLES(MS)) i_dut (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_cfg_stage(stg), .i_cfg_wr(wr),
		.i_cfg_rd(rd), .i_cfg_addr(adr), .i_cfg_wdata(wd), .o_cfg_rdata(rdat),
		.i_port4_power_request(rq4), .i_port5_power_request(rq5),
		.i_port4_link_state_status(ls4), .i_port5_link_state_status(ls5),
		.o_port4_power_control_pin(p4), .o_port5_power_control_pin(p5),
		.o_gpio_sixty_six(g[3]), .o_gpio_sixty_six_oe_n(gn[3]), .o_gpio_six(g[2]),
		.o_gpio_six_oe_n(gn[2]), .o_gpio_five(g[1]), .o_gpio_five_oe_n(gn[1]),
		.o_gpio_four(g[0]), .o_gpio_four_oe_n(gn[0]));
	spc_embedded_dev i_dev4 (.i_ref_clk(clk), .i_pwr({g[3], g[1]}),
		.i_pwr_oe_n({gn[3], gn[1]}), .i_code(c4), .o_link_state_status(ls4));
	spc_embedded_dev i_dev5 (.i_ref_clk(clk), .i_pwr({g[2], g[0]}),
		.i_pwr_oe_n({gn[2], gn[0]}), .i_code(c5), .o_link_state_status(ls5));
	// ----------------
	// Access tasks
	// ----------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		adr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk);
		adr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(rdat, e);
	endtask
	// Bounded, so a dead pin shows as a wrong count
	task automatic wait_g(input logic v, input int lim, output int k);
		k = 0;
		while (g[3] !== v && k < lim) begin
			@(negedge clk);
			k++;
		end
	endtask
	task automatic final_report();
		if (failures == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		failures++;
		final_report();
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		chk({gn, g}, 8'hf0);
		chk({6'h0, p4, p5}, 8'h00);
		for (int i = 0; i < 7; i++) begin
			rd_reg(rv[i][23:8], rv[i][7:0]);
		end
		for (int i = 0; i < 3; i++) begin
			wr_reg(mk[i][23:8], 8'hff);
			rd_reg(mk[i][23:8], mk[i][7:0]);
		end
		stg = 1'b0;
		wr_reg(16'h4176, 8'h33);
		stg = 1'b1;
		rd_reg(16'h4176, 8'h05);
		rq4 = 1'b1;
		@(negedge clk);
		chk({6'h0, p4, p5}, 8'h02);
		rq5 = 1'b1;
		@(negedge clk);
		chk({6'h0, p4, p5}, 8'h03);
		for (int i = 0; i < 6; i++) begin
			rt = rtab[i];
			wr_reg(rt[36:21], rt[20:13]);
			wr_reg(16'h3c48, rt[12:5]);
			wr_reg(16'h4141, {7'h0, rt[4]});
			@(negedge clk);
			chk({gn, g}, {rt[3:0], ~rt[3:0]});
		end
		wr_reg(16'h3c48, 8'h20);
		// Dropped request must reach the split pin and the 2.0 pin alike
		repeat (2) @(negedge clk);
		rq4 = 1'b0;
		repeat (2) @(negedge clk);
		chk({gn[3], g[3], 5'h0, p4}, 8'h00);
		rq4 = 1'b1;
		for (int i = 0; i < 6; i++) begin
			c4 = 4'h0;
			wr_reg(16'h4171, 8'(i + 1));
			wr_reg(16'h4176, (i == 0) ? 8'h00 : 8'h0a);
			t = tms[i] * MS;
			o = ((i == 0) ? 350 : 450) * MS;
			wait_g(1'b1, 9000, n);
			c4 = 4'h7;
			wait_g(1'b0, 12000, n);
			chk({7'h0, n inside {[t - MS - 3:t + MS + 4]}}, 8'h01);
			wait_g(1'b1, 3000 * MS, n);
			chk({7'h0, n inside {[o - MS - 2:o + MS + 2]}}, 8'h01);
			if (i == 0) begin
				wait_g(1'b0, 12000, n);
				chk({7'h0, n inside {[t - MS - 3:t + MS + 4]}}, 8'h01);
			end
		end
		for (int i = 0; i < 6; i++) begin
			nt = ntab[i];
			c4 = 4'h0;
			wr_reg(16'h4171, {4'h0, nt[8:5]});
			wait_g(1'b1, 9000, n);
			c4 = nt[4:1];
			lo = 0;
			for (int k = 1; k < 1500; k++) begin
				@(negedge clk);
				lo += (g[3] !== 1'b1);
				c4 ^= (nt[0] && k % 300 == 0) ? 4'h3 : 4'h0;
			end
			// Compared as a flag; a truncated count could wrap to zero
			chk({7'h0, lo == 0}, 8'h01);
		end
		final_report();
	end
endmodule
`default_nettype wire
